/* File: logic/imc_cfg.svh */
// constants for the idle mode controller
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH
`define IMC_ARM_BIT      0
`define IMC_START_BIT    5
`define IMC_POWER_CONTROL_REGISTER_RST     8'h00
`define IMC_CLK_PERIOD_NS 25
`endif

/* File: logic/imc_pkg.sv */
// types for the idle mode controller
package imc_pkg;
  typedef enum logic [1:0] {
    IMC_RUN,
    IMC_ARMED,
    IMC_IDLE
  } imc_state_t;

  typedef struct packed {
    logic       we;
    logic [7:0] wdata;
  } imc_wr_t;

  typedef struct packed {
    logic ale;
    logic program_fetch_strobe;
  } imc_strobe_t;
endpackage : imc_pkg

/* File: logic/imc_idle_ctrl.sv */
// idle mode entry, clock gating and pin-state control
`timescale 1ns/10ps
`include "imc_cfg.svh"

// Overview of operation
// - in idle the cpu clock and the watchdog are stopped; other peripheral clocks keep running
// - cpu state is held because its clock stops
// - latch-driven port pins hold their level during idle
// - active alternate-function pins keep driving during idle
// - both bus strobes are held high throughout idle while power-down is not asserted
// - port inputs stay functional during idle
// - internal fetch: ports show latch data; power-down drives strobes low
// - external fetch: port 0 floats; port 2 shows address in idle
// - watchdog count is frozen during idle
// - idle entry only while the enable pin is low
// - arm write then immediately start write enters idle
// - a write setting both arm and start does not start idle
// - arm and start bits self-clear and read as zero
// - the start write is the last instruction before gating
// - any enabled interrupt ends idle
// - hardware reset ends idle
// - enable pin high blocks entry; sampled once per instruction
module imc_idle_ctrl (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // cpu side
  input  wire logic                 instr_done,
  input  wire imc_pkg::imc_wr_t     power_control_register_wr,
  input  wire logic                 irq_pending,
  input  wire logic                 ext_fetch,
  input  wire logic                 power_down,
  // enable pin
  input  wire logic                 power_save_enable_pin,
  // normal-mode pin sources
  input  wire imc_pkg::imc_strobe_t strobe_run,
  input  wire logic [7:0]           p0_run,
  input  wire logic [7:0]           p2_run,
  input  wire logic [7:0]           p2_latch,
  input  wire logic                 p0_oe_run,
  // outputs
  output logic                      cpu_clk_en_r,
  output logic                      wdt_run_r,
  output logic                      idle_r,
  output logic [7:0]                power_control_register_ctl_rd_r,
  output imc_pkg::imc_strobe_t      strobe_r,
  output logic [7:0]                p0_out_r,
  output logic                      p0_oe_r,
  output logic [7:0]                p2_out_r
);

  imc_pkg::imc_state_t state_r;
  imc_pkg::imc_state_t state_nxt;
  logic                pse_s1_r;
  logic                pse_s2_r;
  logic                pse_smp_r;
  logic                arm_wr;
  logic                start_wr;

  // two-flop synchroniser on the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pse_s1_r <= 1'b1;
      pse_s2_r <= 1'b1;
    end else begin
      pse_s1_r <= power_save_enable_pin;
      pse_s2_r <= pse_s1_r;
    end
  end

  // sampled once per instruction; resets high so entry is blocked by default
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pse_smp_r <= 1'b1;
    end else if (instr_done) begin
      pse_smp_r <= pse_s2_r;
    end
  end

  always_comb begin
    arm_wr   = power_control_register_wr.we && power_control_register_wr.wdata[`IMC_ARM_BIT] && !power_control_register_wr.wdata[`IMC_START_BIT];
    start_wr = power_control_register_wr.we && power_control_register_wr.wdata[`IMC_START_BIT] && !power_control_register_wr.wdata[`IMC_ARM_BIT];
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      imc_pkg::IMC_RUN: begin
        if (instr_done && arm_wr && !pse_smp_r) begin
          state_nxt = imc_pkg::IMC_ARMED;
        end
      end
      imc_pkg::IMC_ARMED: begin
        if (instr_done) begin
          if (start_wr && !pse_smp_r && !irq_pending) begin
            state_nxt = imc_pkg::IMC_IDLE;
          end else if (arm_wr && !pse_smp_r) begin
            state_nxt = imc_pkg::IMC_ARMED;
          end else begin
            state_nxt = imc_pkg::IMC_RUN;
          end
        end
      end
      imc_pkg::IMC_IDLE: begin
        if (irq_pending) begin
          state_nxt = imc_pkg::IMC_RUN;
        end
      end
    endcase
  end

  // reset ends idle asynchronously
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= imc_pkg::IMC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // only the cpu clock and the watchdog stop; all else keeps clocking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en_r <= 1'b1;
      wdt_run_r    <= 1'b1;
      idle_r       <= 1'b0;
    end else begin
      cpu_clk_en_r <= (state_nxt != imc_pkg::IMC_IDLE);
      wdt_run_r    <= (state_nxt != imc_pkg::IMC_IDLE);
      idle_r       <= (state_nxt == imc_pkg::IMC_IDLE);
    end
  end

  // control bits never read back as set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_ctl_rd_r <= `IMC_POWER_CONTROL_REGISTER_RST;
    end else begin
      power_control_register_ctl_rd_r <= `IMC_POWER_CONTROL_REGISTER_RST;
    end
  end

  // pin states; latches and alternate outputs keep their own drivers since
  // their peripheral clocks run, so only strobes and ports 0/2 are steered here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_r <= '{ale: 1'b1, program_fetch_strobe: 1'b1};
      p0_out_r <= 8'h00;
      p0_oe_r  <= 1'b0;
      p2_out_r <= 8'h00;
    end else if (power_down) begin
      strobe_r <= '{ale: 1'b0, program_fetch_strobe: 1'b0};
      p0_out_r <= p0_run;
      p0_oe_r  <= p0_oe_run && !ext_fetch;
      p2_out_r <= p2_latch;
    end else if (state_nxt == imc_pkg::IMC_IDLE) begin
      strobe_r <= '{ale: 1'b1, program_fetch_strobe: 1'b1};
      if (state_r != imc_pkg::IMC_IDLE) begin
        p0_out_r <= p0_run;
        p2_out_r <= ext_fetch ? p2_run : p2_latch;
      end
      p0_oe_r <= p0_oe_run && !ext_fetch;
    end else begin
      strobe_r <= strobe_run;
      p0_out_r <= p0_run;
      p0_oe_r  <= p0_oe_run;
      p2_out_r <= p2_run;
    end
  end

  // assertions
  strobe_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_r && !$past(power_down) |-> strobe_r.ale && strobe_r.program_fetch_strobe)
    else $error("strobes not high in idle");
  both_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == imc_pkg::IMC_RUN && power_control_register_wr.we && instr_done
    && power_control_register_wr.wdata[`IMC_ARM_BIT] && power_control_register_wr.wdata[`IMC_START_BIT] |=> !idle_r)
    else $error("combined write started idle");
  pin_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    pse_smp_r && state_r != imc_pkg::IMC_IDLE |=> !idle_r)
    else $error("idle entered with enable pin high");
  enable_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(idle_r) |-> !$past(pse_smp_r))
    else $error("idle without enable low");
  entry_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(idle_r) |-> $past(state_r) == imc_pkg::IMC_ARMED && $past(start_wr))
    else $error("idle entered without sequence");
  arm_expire_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == imc_pkg::IMC_ARMED && instr_done && !start_wr && !arm_wr
    |=> state_r == imc_pkg::IMC_RUN)
    else $error("arm outlived one instruction");
  irq_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_r && irq_pending |=> !idle_r && cpu_clk_en_r)
    else $error("interrupt did not end idle");
  clk_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_r |-> !cpu_clk_en_r && !wdt_run_r)
    else $error("clock or watchdog running in idle");
  read_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    power_control_register_ctl_rd_r[`IMC_ARM_BIT] == 1'b0 && power_control_register_ctl_rd_r[`IMC_START_BIT] == 1'b0)
    else $error("control bit read as one");
  port2_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_r && $past(idle_r) && !$past(power_down) |-> $stable(p2_out_r))
    else $error("port 2 changed in idle");
  pd_strobe_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(power_down) |-> !strobe_r.ale && !strobe_r.program_fetch_strobe)
    else $error("strobes not low in power-down");
  port0_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rst_n) && $past(ext_fetch) && ($past(power_down) || idle_r) |-> !p0_oe_r)
    else $error("port 0 driven with external fetch");
  port0_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_r && $past(idle_r) && !$past(power_down) |-> $stable(p0_out_r))
    else $error("port 0 data changed in idle");

  idle_entry_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(idle_r));
  idle_exit_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(idle_r));
  arm_lapse_c: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == imc_pkg::IMC_ARMED ##1 state_r == imc_pkg::IMC_RUN);
  blocked_c: cover property (@(posedge clk) disable iff (!rst_n)
    pse_smp_r && arm_wr && instr_done);

endmodule : imc_idle_ctrl

/* File: tb/imc_cpu_model.sv */
// cpu and enable-pin model for the idle controller
`timescale 1ns/10ps
module imc_cpu_model (
  // clock
  input  wire logic        clk,
  // cpu side
  output logic             instr_done,
  output imc_pkg::imc_wr_t power_control_register_wr,
  // enable pin
  output logic             power_save_enable_pin
);
  initial begin
    instr_done = 1'b0;
    power_control_register_wr = '0;
    power_save_enable_pin = 1'b1;
  end
  // one byte-wide write per instruction, idle data inverted
  task automatic exec(input logic w, input logic [7:0] d);
    @(negedge clk);
    instr_done <= 1'b1;
    power_control_register_wr <= '{we: w, wdata: d};
    @(negedge clk);
    instr_done <= 1'b0;
    power_control_register_wr <= '{we: 1'b0, wdata: ~d};
  endtask : exec
  // pin settles through the synchroniser before the sequence starts
  task automatic pin(input logic v);
    power_save_enable_pin <= v;
    repeat (4) exec(1'b0, 8'h00);
  endtask : pin
endmodule : imc_cpu_model

/* File: tb/test_idle_mode_controller.sv */
// self-checking bench for the idle controller
`timescale 1ns/10ps
module test_idle_mode_controller;
  logic                 clk;
  logic                 rst_n;
  logic                 irq;
  logic                 instr_done;
  logic                 pin_n;
  imc_pkg::imc_wr_t     wr;
  imc_pkg::imc_strobe_t strobe_r;
  logic [7:0]           p2_run, p0_run, p2_latch, x2, x0, rd, p0_out, p2_out;
  logic                 clk_en, wdt_run, idle, p0_oe, ext, pd;
  logic [1:0]           srun;
  // note: {idle, strobes, port 0 enable, port 2, port 0}
  logic [19:0]          exp_q[$];
  logic [19:0]          e;
  int                   err_total, checks;
  event                 chk_ev;
  // per test: three writes {we,data}, pin level, expected idle
  logic [8:0] seq [6][3] = '{'{9'h000, 9'h101, 9'h120}, '{9'h000, 9'h000, 9'h121},
    '{9'h000, 9'h000, 9'h120}, '{9'h101, 9'h001, 9'h120}, '{9'h000, 9'h101, 9'h120},
    '{9'h101, 9'h101, 9'h120}};
  logic [5:0] pin_t = 6'b010000;
  logic [5:0] exp_t = 6'b100001;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  imc_cpu_model cpu_u (.clk(clk), .instr_done(instr_done), .power_control_register_wr(wr),
    .power_save_enable_pin(pin_n));
  // run strobes low so the idle level must come from the controller
  imc_idle_ctrl dut_u (.clk(clk), .rst_n(rst_n), .instr_done(instr_done), .power_control_register_wr(wr),
    .irq_pending(irq), .ext_fetch(ext), .power_down(pd), .power_save_enable_pin(pin_n),
    .strobe_run(srun), .p0_run(p0_run), .p2_run(p2_run), .p2_latch(p2_latch),
    .p0_oe_run(1'b1), .cpu_clk_en_r(clk_en), .wdt_run_r(wdt_run), .idle_r(idle),
    .power_control_register_ctl_rd_r(rd), .strobe_r(strobe_r), .p0_out_r(p0_out), .p0_oe_r(p0_oe),
    .p2_out_r(p2_out));
  task automatic bad(input string m);
    $display("BAD %0t %s", $time, m);
    err_total++;
  endtask : bad
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // pass-through pin state outside idle and power-down
  function automatic logic [19:0] run_note();
    return {1'b0, srun, 1'b1, p2_run, p0_run};
  endfunction : run_note
  always @(chk_ev) begin
    e = exp_q.pop_front();
    checks += 5;
    if (idle !== e[19] || clk_en !== ~e[19]) bad("idle state");
    if (wdt_run !== ~e[19]) bad("watchdog");
    if (rd !== 8'h00) bad("control read");
    if (strobe_r !== e[18:17] || p0_oe !== e[16]) bad("strobes");
    if (p2_out !== e[15:8] || p0_out !== e[7:0]) bad("port data");
  end
  initial begin
    {rst_n, irq, pd, ext, srun, p2_run, p0_run, p2_latch} = '0;
    err_total = 0;
    checks = 0;
    void'($urandom(34));
    repeat (7) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      ext = i[0];
      p2_run = $urandom();
      p0_run = $urandom();
      p2_latch = $urandom();
      cpu_u.pin(pin_t[i]);
      for (int k = 0; k < 3; k++) cpu_u.exec(seq[i][k][8], seq[i][k][7:0]);
      repeat (2) @(negedge clk);
      x2 = ext ? p2_run : p2_latch;
      x0 = p0_run;
      // port 2 and port 0 data sources move while idle; pins must not follow
      {p2_run, p2_latch, p0_run} = ~{p2_run, p2_latch, p0_run};
      @(negedge clk);
      exp_q.push_back(exp_t[i] ? {3'b111, ~ext, x2, x0} : run_note());
      -> chk_ev;
      irq = 1'b1;
      repeat (2) @(negedge clk);
      irq = 1'b0;
      exp_q.push_back(run_note());
      -> chk_ev;
      $display("test %0d done", i);
    end
    // reset in idle; two cycles suffice while the clock runs
    cpu_u.pin(1'b0);
    cpu_u.exec(1'b1, 8'h01);
    cpu_u.exec(1'b1, 8'h20);
    exp_q.push_back({3'b111, ~ext, ext ? p2_run : p2_latch, p0_run});
    -> chk_ev;
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    exp_q.push_back(run_note());
    -> chk_ev;
    $display("test reset done");
    // run strobes high so the power-down low level shows
    srun = 2'b11;
    for (int k = 0; k < 2; k++) begin
      ext = k[0];
      pd = 1'b1;
      @(negedge clk);
      exp_q.push_back({3'b000, ~ext, p2_latch, p0_run});
      -> chk_ev;
      pd = 1'b0;
      @(negedge clk);
    end
    $display("test power-down done");
    give_verdict();
  end
endmodule : test_idle_mode_controller
